// File: src/otp_status_link.sv
// Purpose: device side of a single-wire otp link with status write flow
// Assumes: data pin input synchronous to ref_clk_in; pull-up outside
// Notes: programming voltage is sensed on a separate input
`timescale 1ns/1ps
module otp_status_link (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic data_in,
    input wire logic programming_voltage_in,
    output otp_link_pkg::pin_drive_s data_drive_out,
    output logic [2:0] status_addr_out,
    output logic link_reset_out
);
    import otp_link_pkg::*;

    // microsecond tick divider
    logic [5:0] div_cnt, next_div_cnt;
    logic tick, next_tick;
    always_comb begin
        next_div_cnt = (div_cnt == TICK_LAST) ? 6'h00 : div_cnt + 6'h01;
        next_tick = (div_cnt == TICK_LAST);
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            div_cnt <= 6'h00;
            tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
        end
    end

    // bit-level engine: slots, reset detection, presence
    wire_state_e ws, next_ws;
    logic [9:0] us, next_us;
    logic data_q, next_data_q;
    logic pull, next_pull;
    logic bit_valid, next_bit_valid;
    logic bit_val, next_bit_val;
    logic wire_rst, next_wire_rst;
    logic tx_bit;      // bit sent in the current read slot
    logic tx_active;   // a read slot is due in the command layer
    logic prog_busy;   // long lows are a program pulse, not a reset
    always_comb begin
        next_ws = ws;
        next_us = us;
        next_data_q = data_in;
        next_pull = pull;
        next_bit_valid = 1'b0;
        next_bit_val = bit_val;
        next_wire_rst = 1'b0;
        if (tick && us != 10'h3ff)
            next_us = us + 10'h001;
        case (ws)
            WS_IDLE: begin
                next_pull = 1'b0;
                if (!data_q) begin
                    next_ws = WS_LOW;
                    next_us = 10'h000;
                    next_pull = tx_active && !tx_bit;
                end
            end
            WS_LOW: begin
                if (pull && us >= READ_HOLD)
                    next_pull = 1'b0;
                if (us >= SAMPLE_AT && !pull) begin
                    next_bit_val = data_q;
                    next_bit_valid = 1'b1;
                    next_ws = WS_SLOT;
                end
            end
            WS_SLOT: begin
                if (data_q)
                    next_ws = WS_IDLE;
                else if (us >= RESET_MIN && !prog_busy) begin
                    next_wire_rst = 1'b1;
                    next_ws = WS_PRES_WAIT;
                end
            end
            WS_PRES_WAIT: begin
                if (data_q) begin
                    next_ws = WS_PRES;
                    next_us = 10'h000;
                end
            end
            WS_PRES: begin
                if (us >= PRES_WAIT)
                    next_pull = 1'b1;
                if (us >= PRES_WAIT + PRES_LEN) begin
                    next_pull = 1'b0;
                    // data_q still shows our own pull for a cycle; going
                    // straight to idle would open a false slot
                    next_ws = WS_SLOT;
                end
            end
            default: next_ws = WS_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ws <= WS_IDLE;
            us <= 10'h000;
            data_q <= 1'b1;
            pull <= 1'b0;
            bit_valid <= 1'b0;
            bit_val <= 1'b1;
            wire_rst <= 1'b0;
        end else begin
            ws <= next_ws;
            us <= next_us;
            data_q <= next_data_q;
            pull <= next_pull;
            bit_valid <= next_bit_valid;
            bit_val <= next_bit_val;
            wire_rst <= next_wire_rst;
        end
    end

    // crc step, x^8+x^5+x^4+1 shifted lsb first
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = (c >> 1) ^ (fb ? CRC_POLY : 8'h00);
    endfunction

    // command layer
    cmd_state_e cs, next_cs;
    logic [7:0] shreg, next_shreg;
    logic [2:0] bcnt, next_bcnt;
    logic [7:0] crc, next_crc;
    logic [7:0] cmd, next_cmd;
    logic [15:0] addr, next_addr;
    logic [7:0] wdata, next_wdata;
    logic [7:0] txbyte, next_txbyte;
    logic saw_pv, next_saw_pv;
    logic [7:0] status_mem [0:7];
    logic [7:0] next_mem_val;
    logic mem_we;
    logic [7:0] rx_byte;
    logic byte_done;
    logic [7:0] cur_status;

    assign rx_byte = {bit_val, shreg[7:1]};
    assign byte_done = bit_valid && bcnt == 3'd7;
    assign cur_status = status_mem[addr[2:0]];
    assign tx_bit = txbyte[bcnt];
    assign tx_active = (cs == ST_CRC_OUT) || (cs == ST_VERIFY) ||
                       (cs == ST_PROFILE) || (cs == ST_IDLE_ONES);
    assign prog_busy = (cs == ST_PROG_WAIT);

    always_comb begin
        next_cs = cs;
        next_shreg = shreg;
        next_bcnt = bcnt;
        next_crc = crc;
        next_cmd = cmd;
        next_addr = addr;
        next_wdata = wdata;
        next_txbyte = txbyte;
        next_saw_pv = saw_pv;
        next_mem_val = cur_status & wdata;
        mem_we = 1'b0;
        if (bit_valid) begin
            next_shreg = rx_byte;
            next_bcnt = bcnt + 3'd1;
            if (cs == ST_FUNC_CMD || cs == ST_ADDR_LO || cs == ST_ADDR_HI ||
                cs == ST_DATA)
                next_crc = crc_step(crc, bit_val);
        end
        case (cs)
            ST_WAIT_RESET: next_bcnt = 3'd0;
            ST_ROM_CMD: if (byte_done) begin
                next_crc = 8'h00;
                case (rx_byte)
                    CMD_READ_ROM, CMD_MATCH_ROM, CMD_SEARCH_ROM,
                    CMD_SKIP_ROM: next_cs = ST_FUNC_CMD;
                    default: next_cs = ST_WAIT_RESET;
                endcase
            end
            ST_FUNC_CMD: if (byte_done) begin
                next_cmd = rx_byte;
                case (rx_byte)
                    CMD_WRITE_STATUS, CMD_READ_STATUS, CMD_READ_FIELD,
                    CMD_READ_PAGE, CMD_WRITE_MEM: next_cs = ST_ADDR_LO;
                    CMD_PROFILE: begin
                        next_txbyte = PROFILE_REPLY;
                        next_cs = ST_PROFILE;
                    end
                    default: next_cs = ST_WAIT_RESET;
                endcase
            end
            ST_ADDR_LO: if (byte_done) begin
                next_addr[7:0] = rx_byte;
                next_cs = ST_ADDR_HI;
            end
            ST_ADDR_HI: if (byte_done) begin
                next_addr[15:8] = rx_byte;
                // only the status write flow is carried further here
                next_cs = (cmd == CMD_WRITE_STATUS) ? ST_DATA : ST_IDLE_ONES;
                next_txbyte = STATUS_ERASED;
            end
            ST_DATA: if (byte_done) begin
                next_wdata = rx_byte;
                next_txbyte = crc_step(crc, bit_val);
                next_cs = ST_CRC_OUT;
            end
            ST_CRC_OUT: if (byte_done)
                next_cs = ST_PROG_CMD;
            ST_PROG_CMD: if (byte_done) begin
                // program only honoured inside the write flow
                if (rx_byte == CMD_PROGRAM) begin
                    next_cs = ST_PROG_WAIT;
                    next_saw_pv = 1'b0;
                end else
                    next_cs = ST_IDLE_ONES;
                next_txbyte = STATUS_ERASED;
            end
            ST_PROG_WAIT: begin
                if (programming_voltage_in)
                    next_saw_pv = 1'b1;
                else if (saw_pv && data_q) begin
                    // pulse ended, wire back at pullup level
                    if (addr[2:0] != STATUS_LAST_IDX)
                        mem_we = 1'b1;
                    next_txbyte = next_mem_val;
                    if (addr[2:0] == STATUS_LAST_IDX)
                        next_txbyte = cur_status;
                    next_bcnt = 3'd0;
                    next_cs = ST_VERIFY;
                end
            end
            ST_VERIFY: if (byte_done) begin
                next_addr = addr + 16'h0001;
                next_crc = next_addr[7:0];
                next_cs = ST_DATA;
            end
            ST_PROFILE: if (byte_done)
                next_cs = ST_IDLE_ONES;
            ST_IDLE_ONES: next_txbyte = STATUS_ERASED;
            default: next_cs = ST_WAIT_RESET;
        endcase
        if (wire_rst) begin
            next_cs = ST_ROM_CMD;
            next_bcnt = 3'd0;
            next_crc = 8'h00;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cs <= ST_WAIT_RESET;
            shreg <= 8'h00;
            bcnt <= 3'd0;
            crc <= 8'h00;
            cmd <= 8'h00;
            addr <= 16'h0000;
            wdata <= STATUS_ERASED;
            txbyte <= STATUS_ERASED;
            saw_pv <= 1'b0;
        end else begin
            cs <= next_cs;
            shreg <= next_shreg;
            bcnt <= next_bcnt;
            crc <= next_crc;
            cmd <= next_cmd;
            addr <= next_addr;
            wdata <= next_wdata;
            txbyte <= next_txbyte;
            saw_pv <= next_saw_pv;
        end
    end

    // status field storage, erased to ones, last byte fixed zero
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 7; i++)
                status_mem[i] <= STATUS_ERASED;
            status_mem[7] <= STATUS_LAST_VAL;
        end else if (mem_we) begin
            status_mem[addr[2:0]] <= next_mem_val;
        end
    end

    // registered outputs
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            data_drive_out <= '{dout: 1'b1, oe_n: 1'b1};
            status_addr_out <= 3'd0;
            link_reset_out <= 1'b0;
        end else begin
            data_drive_out <= '{dout: !next_pull, oe_n: !next_pull};
            status_addr_out <= next_addr[2:0];
            link_reset_out <= next_wire_rst;
        end
    end
endmodule

// File: src/otp_link_pkg.sv
// Purpose: constants and types for the single-wire otp status programmer
// Assumes: 40 MHz clock, one tick per microsecond from a divider
// Notes: timing counts other than the tick divider are in microsecond ticks
package otp_link_pkg;
    localparam int CLK_MHZ = 40;
    localparam int TICK_DIV = CLK_MHZ;        // cycles per microsecond
    localparam logic [5:0] TICK_LAST = 6'(TICK_DIV - 1);
    // wire timing in microseconds
    localparam int RESET_MIN_US = 480;
    localparam int SAMPLE_US = 30;            // write slot sample point
    localparam int READ_HOLD_US = 30;         // device holds a read zero
    localparam int PRES_WAIT_US = 30;
    localparam int PRES_LEN_US = 120;
    localparam int PROG_MIN_US = 480;         // low time seen as program pulse
    localparam logic [9:0] RESET_MIN = 10'(RESET_MIN_US);
    localparam logic [9:0] SAMPLE_AT = 10'(SAMPLE_US);
    localparam logic [9:0] READ_HOLD = 10'(READ_HOLD_US);
    localparam logic [9:0] PRES_WAIT = 10'(PRES_WAIT_US);
    localparam logic [9:0] PRES_LEN = 10'(PRES_LEN_US);
    // command codes
    localparam logic [7:0] CMD_READ_ROM = 8'h33;
    localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
    localparam logic [7:0] CMD_SEARCH_ROM = 8'hf0;
    localparam logic [7:0] CMD_SKIP_ROM = 8'hcc;
    localparam logic [7:0] CMD_READ_FIELD = 8'hf0;
    localparam logic [7:0] CMD_READ_STATUS = 8'haa;
    localparam logic [7:0] CMD_READ_PAGE = 8'hc3;
    localparam logic [7:0] CMD_WRITE_MEM = 8'h0f;
    localparam logic [7:0] CMD_PROFILE = 8'h99;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'h5a;
    localparam logic [7:0] PROFILE_REPLY = 8'h55;
    // status field
    localparam logic [7:0] STATUS_ERASED = 8'hff;
    localparam logic [7:0] STATUS_LAST_VAL = 8'h00;
    localparam logic [2:0] STATUS_LAST_IDX = 3'd7;
    localparam logic [7:0] CRC_POLY = 8'h8c;  // x^8+x^5+x^4+1, reflected

    typedef enum logic [3:0] {
        ST_WAIT_RESET, ST_ROM_CMD, ST_FUNC_CMD, ST_ADDR_LO, ST_ADDR_HI,
        ST_DATA, ST_CRC_OUT, ST_PROG_CMD, ST_PROG_WAIT, ST_VERIFY,
        ST_PROFILE, ST_IDLE_ONES
    } cmd_state_e;

    typedef enum logic [2:0] {
        WS_IDLE, WS_LOW, WS_SLOT, WS_PRES_WAIT, WS_PRES
    } wire_state_e;

    // open-drain data pin, oe low while the device pulls low
    typedef struct packed {
        logic dout;
        logic oe_n;
    } pin_drive_s;
endpackage

// File: tb/otp_status_link_props.sv
// Purpose: port checker for the otp status link
// Assumes: single clock, wire level seen on data_in
// Notes: long spans are measured by helper counters
`timescale 1ns/1ps
module otp_status_link_props (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic data_in,
    input wire logic programming_voltage_in,
    input otp_link_pkg::pin_drive_s data_drive_out,
    input wire logic [2:0] status_addr_out,
    input wire logic link_reset_out
);
    import otp_link_pkg::*;
    localparam int RST_CYC = (RESET_MIN_US - 1) * CLK_MHZ;
    localparam int PULL_MAX = (PRES_LEN_US + 2) * CLK_MHZ;
    localparam int PRES_MAX = 200 * CLK_MHZ;
    logic [15:0] low_run, last_low, pull_run, pres_cnt;
    logic [15:0] next_low_run, next_last_low, next_pull_run, next_pres_cnt;
    // lengths of wire lows, device pulls and the presence wait
    always_comb begin
        next_low_run = data_in ? 16'h0 : low_run + 16'h1;
        next_last_low = (data_in && low_run != 16'h0) ? low_run : last_low;
        if (!data_in) begin
            next_last_low = 16'h0;
        end
        next_pull_run = data_drive_out.oe_n ? 16'h0 : pull_run + 16'h1;
        next_pres_cnt = (pres_cnt != 16'h0) ? pres_cnt + 16'h1 : 16'h0;
        if (!data_drive_out.oe_n) begin
            next_pres_cnt = 16'h0;
        end
        if (link_reset_out) begin
            next_pres_cnt = 16'h1;
        end
    end
    // register the helper counters
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            low_run <= 16'h0;
            last_low <= 16'h0;
            pull_run <= 16'h0;
            pres_cnt <= 16'h0;
        end else begin
            low_run <= next_low_run;
            last_low <= next_last_low;
            pull_run <= next_pull_run;
            pres_cnt <= next_pres_cnt;
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence s_one_shot;
        link_reset_out ##1 !link_reset_out;
    endsequence
    sequence s_pull_start;
        $fell(data_drive_out.oe_n);
    endsequence
    property p_reset_quiet;
        $fell(sys_rst_in) |-> data_drive_out.oe_n && !link_reset_out
            && status_addr_out == 3'h0;
    endproperty
    property p_pull_zero;
        !data_drive_out.oe_n |-> !data_drive_out.dout;
    endproperty
    property p_pull_len;
        pull_run <= PULL_MAX;
    endproperty
    property p_reset_low;
        link_reset_out |-> low_run >= RST_CYC || last_low >= RST_CYC;
    endproperty
    property p_reset_pulse;
        link_reset_out |-> s_one_shot;
    endproperty
    property p_presence;
        pres_cnt <= PRES_MAX;
    endproperty
    property p_pull_cause;
        s_pull_start |-> !$past(data_in) || pres_cnt != 16'h0;
    endproperty
    property p_vpp_no_pull;
        programming_voltage_in |-> data_drive_out.oe_n;
    endproperty
    property p_vpp_addr;
        programming_voltage_in |-> $stable(status_addr_out);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not at reset values");
    a_pull_zero: assert property (p_pull_zero)
        else $error("pull with data high");
    a_pull_len: assert property (p_pull_len)
        else $error("device pull too long");
    a_reset_low: assert property (p_reset_low)
        else $error("wire reset without long low");
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("wire reset flag not one cycle");
    a_presence: assert property (p_presence)
        else $error("no presence after wire reset");
    a_pull_cause: assert property (p_pull_cause)
        else $error("pull started on idle wire");
    a_vpp_no_pull: assert property (p_vpp_no_pull)
        else $error("pull during program pulse");
    a_vpp_addr: assert property (p_vpp_addr)
        else $error("address moved during program pulse");
endmodule
bind otp_status_link otp_status_link_props u_props (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .data_in(data_in),
    .programming_voltage_in(programming_voltage_in),
    .data_drive_out(data_drive_out),
    .status_addr_out(status_addr_out),
    .link_reset_out(link_reset_out)
);

// File: tb/host_master_model.sv
// Purpose: host bus master on the single data wire
// Assumes: pull-up on the wire, one microsecond is 40 cycles
// Notes: slots kept near minimum length to shorten the run
`timescale 1ns/1ps
module host_master_model #(
    parameter int PROG_US = 100
) (
    input wire logic ref_clk_in,
    input otp_link_pkg::pin_drive_s data_drive_in,
    output logic wire_level_out,
    output logic programming_voltage_out
);
    import otp_link_pkg::*;
    logic host_low;
    // wired-and of host, device and pull-up
    assign wire_level_out = !host_low
        && (data_drive_in.oe_n || data_drive_in.dout);
    // wire starts idle
    initial begin
        host_low = 1'b0;
        programming_voltage_out = 1'b0;
    end
    task automatic wait_us(input int n);
        repeat (n * CLK_MHZ) @(posedge ref_clk_in);
    endtask
    task automatic reset_pulse(output logic seen);
        host_low <= 1'b1;
        wait_us(490);
        host_low <= 1'b0;
        wait_us(45);
        seen = !wire_level_out;
        wait_us(125);
    endtask
    task automatic write_bit(input logic b);
        host_low <= 1'b1;
        wait_us(2);
        host_low <= !b;
        wait_us(30);
        host_low <= 1'b0;
        wait_us(2);
    endtask
    task automatic read_bit(output logic b);
        host_low <= 1'b1;
        wait_us(1);
        host_low <= 1'b0;
        wait_us(14);
        b = wire_level_out;
        wait_us(18);
    endtask
    task automatic write_byte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            write_bit(d[i]);
        end
    endtask
    task automatic read_byte(output logic [7:0] d);
        logic b;
        for (int i = 0; i < 8; i++) begin
            read_bit(b);
            d[i] = b;
        end
    endtask
    task automatic program_pulse();
        programming_voltage_out <= 1'b1;
        wait_us(PROG_US);
        programming_voltage_out <= 1'b0;
        wait_us(5);
    endtask
endmodule

// File: tb/test_otp_status_link.sv
// Purpose: self-checking bench for the otp status link
// Assumes: host model drives the wire, device answers through DUT
// Notes: expected crc values are built by the bench itself
`timescale 1ns/1ps
module test_otp_status_link;
    import otp_link_pkg::*;
    logic ref_clk_in;
    logic sys_rst_in;
    logic wire_level;
    logic prog_volt;
    pin_drive_s data_drive;
    logic [2:0] status_addr;
    logic link_reset;
    int mismatches;
    int num_checks;
    otp_status_link DUT (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .data_in(wire_level),
        .programming_voltage_in(prog_volt),
        .data_drive_out(data_drive),
        .status_addr_out(status_addr),
        .link_reset_out(link_reset)
    );
    host_master_model host (
        .ref_clk_in(ref_clk_in),
        .data_drive_in(data_drive),
        .wire_level_out(wire_level),
        .programming_voltage_out(prog_volt)
    );
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic t_status_write();
        logic seen;
        logic [7:0] r;
        host.reset_pulse(seen);
        chk_bit(seen, 1'b1);
        host.write_byte(CMD_SKIP_ROM);
        host.write_byte(CMD_WRITE_STATUS);
        host.write_byte(8'h02);
        host.write_byte(8'h00);
        host.write_byte(8'ha5);
        host.read_byte(r);
        chk_byte(r, crc8(crc8(crc8(crc8(8'h00, CMD_WRITE_STATUS), 8'h02),
            8'h00), 8'ha5));
        chk_byte({5'h0, status_addr}, 8'h02);
        host.write_byte(CMD_PROGRAM);
        host.program_pulse();
        host.read_byte(r);
        chk_byte(r, STATUS_ERASED & 8'ha5);
        chk_byte({5'h0, status_addr}, 8'h03);
        host.write_byte(8'h0f);
        host.read_byte(r);
        chk_byte(r, crc8(8'h03, 8'h0f));
    endtask
    task automatic t_profile();
        logic seen;
        logic [7:0] r;
        host.reset_pulse(seen);
        chk_bit(seen, 1'b1);
        host.write_byte(CMD_SKIP_ROM);
        host.write_byte(CMD_PROFILE);
        host.read_byte(r);
        chk_byte(r, PROFILE_REPLY);
    endtask
    task automatic t_sys_reset();
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge ref_clk_in);
        chk_byte({5'h0, status_addr}, 8'h00);
        chk_bit(data_drive.oe_n, 1'b1);
        chk_bit(link_reset, 1'b0);
    endtask
    task automatic close_out();
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // free-running clock
    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = !ref_clk_in;
    end
    // reset, then the scenarios in order
    initial begin
        mismatches = 0;
        num_checks = 0;
        sys_rst_in = 1'b1;
        repeat (8) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge ref_clk_in);
        t_status_write();
        t_profile();
        t_sys_reset();
        close_out();
    end
    // cut a hang short
    initial begin
        #8_000_000;
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
